// [logic/cei_pkg.sv]
// Constants and types shared by the CAN error status and interrupt enable block
package cei_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_LAST_ERR    = 16'hFF92;
    localparam logic [15:0] IDX_ERR_SUMMARY = 16'hFF93;
    localparam logic [15:0] IDX_ERR_COUNT   = 16'hFF94;
    localparam logic [15:0] IDX_IRQ_ENABLE  = 16'hFF96;
    localparam logic [15:0] IDX_IRQ_STATUS  = 16'hFF98;
    localparam logic [15:0] IDX_CONTROL     = 16'hFFA0;

    // Reset values
    localparam logic [2:0]  LAST_ERR_RST   = 3'h0;
    localparam logic [5:0]  IRQ_ENABLE_RST = 6'h00;
    localparam logic [5:0]  IRQ_STATUS_RST = 6'h00;
    localparam logic [8:0]  TX_COUNT_RST   = 9'h000;
    localparam logic [7:0]  RX_COUNT_RST   = 8'h00;

    // Error codes
    localparam logic [2:0]  CODE_NONE    = 3'h0;
    localparam logic [2:0]  CODE_STUFF   = 3'h1;
    localparam logic [2:0]  CODE_FORM    = 3'h2;
    localparam logic [2:0]  CODE_ACK     = 3'h3;
    localparam logic [2:0]  CODE_BIT_REC = 3'h4;
    localparam logic [2:0]  CODE_BIT_DOM = 3'h5;
    localparam logic [2:0]  CODE_CRC     = 3'h6;

    // Counter thresholds and steps
    localparam logic [8:0]  LVL_WARN      = 9'h060;
    localparam logic [8:0]  LVL_PASSIVE   = 9'h080;
    localparam logic [8:0]  LVL_BUS_OFF   = 9'h100;
    localparam logic [7:0]  RX_EXIT_VALUE = 8'h77;
    localparam logic [7:0]  RX_MAX        = 8'hFF;
    localparam logic [8:0]  STEP_BIG      = 9'h008;

    // Level field patterns
    localparam logic [1:0]  LEVEL_LOW  = 2'h0;
    localparam logic [1:0]  LEVEL_WARN = 2'h1;
    localparam logic [1:0]  LEVEL_PASS = 2'h3;

    // Field positions
    localparam int SET_LSB      = 8;
    localparam int BUS_OFF_BIT  = 4;
    localparam int CLR_CNT_BIT  = 0;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_LAST_ERR, SEL_SUMMARY, SEL_COUNT, SEL_ENABLE, SEL_STATUS, SEL_CONTROL
    } cei_sel_t;

endpackage

// [logic/cei_top.sv]
// CAN error code, error counters, status summary and interrupt enable with an AXI4-Lite slave
// Function
// - Last error code survives the switch into initialization mode.
// - Software writes to the last error register take effect only when zero.
// - Code 0 none, 1 stuff, 2 form, 3 acknowledge, 6 CRC; 7 undefined.
// - Code 4: sent recessive saw dominant; code 5: sent dominant saw recessive.
// - Bus-off flag set while transmit count is 256 or more.
// - Transmit level: 00 below 96, 01 for 96..127, 11 from 128.
// - Receive level: 00 below 96, 01 for 96..127, 11 from 128.
// - Counter register: transmit bits 7..0, receive 14..8, passive flag 15.
// - Receive passive flag is one while receive count is 128 or more.
// - Receive count field carries no meaning while receive level is passive.
// - Transmit count field carries no meaning while bus-off.
// - Counters move by the CAN fault confinement steps.
// - Six enable bits, reset zero, gate matching interrupt sources.
// - Enable bits written by set bits 13..8 and clear bits 5..0.
// - Counter clear request clears counters and summary in init mode, then self-clears.
// - Sources high to low: wakeup, arbitration loss, protocol error, status change, rx, tx.
`timescale 1ns/1ps
`default_nettype none

module cei_top #(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Protocol engine: mode and error detection pulses
    input  wire logic              init_mode,
    input  wire logic              stuff_err,
    input  wire logic              form_err,
    input  wire logic              ack_err,
    input  wire logic              bit_rec_err,
    input  wire logic              bit_dom_err,
    input  wire logic              crc_err,
    // Protocol engine: fault confinement steps
    input  wire logic              tx_count_add8,
    input  wire logic              tx_count_sub1,
    input  wire logic              rx_count_add1,
    input  wire logic              rx_count_add8,
    input  wire logic              rx_count_sub1,
    input  wire logic              bus_off_recovered,
    // Protocol engine: interrupt events
    input  wire logic              wakeup_evt,
    input  wire logic              arb_loss_evt,
    input  wire logic              rx_valid_evt,
    input  wire logic              tx_done_evt,
    // Interrupt
    output logic                   irq
);

    // The index compare needs at least one address bit above the 16-bit index
    if (ADDR_W < 19 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be 19 to 32");
    end

    function automatic cei_pkg::cei_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        if      (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_LAST_ERR})    reg_sel = cei_pkg::SEL_LAST_ERR;
        else if (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_ERR_SUMMARY}) reg_sel = cei_pkg::SEL_SUMMARY;
        else if (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_ERR_COUNT})   reg_sel = cei_pkg::SEL_COUNT;
        else if (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_IRQ_ENABLE})  reg_sel = cei_pkg::SEL_ENABLE;
        else if (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_IRQ_STATUS})  reg_sel = cei_pkg::SEL_STATUS;
        else if (idx == {{(ADDR_W-18){1'b0}}, cei_pkg::IDX_CONTROL})     reg_sel = cei_pkg::SEL_CONTROL;
        else                                                             reg_sel = cei_pkg::SEL_NONE;
    endfunction

    // Pattern 10 is never produced by construction
    function automatic logic [1:0] count_level(input logic [8:0] cnt);
        if (cnt >= cei_pkg::LVL_PASSIVE)   count_level = cei_pkg::LEVEL_PASS;
        else if (cnt >= cei_pkg::LVL_WARN) count_level = cei_pkg::LEVEL_WARN;
        else                               count_level = cei_pkg::LEVEL_LOW;
    endfunction

    // Reset release synchroniser
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Block state
    logic [2:0]  last_err;
    logic [8:0]  tx_count;
    logic [7:0]  rx_count;
    logic [5:0]  irq_enable;
    logic [5:0]  irq_status;
    logic        clear_req;
    logic [7:0]  summary_prev;

    logic        bus_off_flag;
    logic [1:0]  tx_level;
    logic [1:0]  rx_level;
    logic        rx_passive_flag;
    logic [7:0]  error_state_summary;
    logic [15:0] error_counters;
    logic        err_any;
    logic [5:0]  irq_src;

    assign bus_off_flag        = (tx_count >= cei_pkg::LVL_BUS_OFF);
    assign tx_level            = count_level(tx_count);
    assign rx_level            = count_level({1'b0, rx_count});
    assign rx_passive_flag     = ({1'b0, rx_count} >= cei_pkg::LVL_PASSIVE);
    assign error_state_summary = {3'h0, bus_off_flag, tx_level, rx_level};
    // Low count bits only; meaningless while passive or bus-off
    assign error_counters = {rx_passive_flag, rx_count[6:0], tx_count[7:0]};
    assign err_any = stuff_err | form_err | ack_err | bit_rec_err | bit_dom_err | crc_err;
    assign irq_src = {wakeup_evt, arb_loss_evt, err_any,
                      error_state_summary != summary_prev, rx_valid_evt, tx_done_evt};

    // AXI write path: address and data taken in either order
    logic [ADDR_W-1:0] aw_addr_q;
    logic              aw_held;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              w_held;
    logic              wr_fire;
    cei_pkg::cei_sel_t wr_sel;
    logic [15:0]       wr_val;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel        = reg_sel(aw_addr_q);
    // Disabled byte lanes count as zero; with lane 1 off an enable write only clears, with lane 0 off it only sets
    assign wr_val = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held   <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cei_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == cei_pkg::SEL_NONE) ? cei_pkg::RESP_SLVERR : cei_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read path
    cei_pkg::cei_sel_t rd_sel;
    logic [15:0]       rd_val;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_sel        = reg_sel(s_axi_araddr);

    always_comb begin
        rd_val = 16'h0;
        unique case (rd_sel)
            cei_pkg::SEL_LAST_ERR: rd_val = {13'h0, last_err};
            cei_pkg::SEL_SUMMARY:  rd_val = {8'h0, error_state_summary};
            cei_pkg::SEL_COUNT:    rd_val = error_counters;
            cei_pkg::SEL_ENABLE:   rd_val = {10'h0, irq_enable};
            cei_pkg::SEL_STATUS:   rd_val = {10'h0, irq_status};
            cei_pkg::SEL_CONTROL:  rd_val = {15'h0, clear_req};
            cei_pkg::SEL_NONE:     rd_val = 16'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= cei_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0, rd_val};
            s_axi_rresp  <= (rd_sel == cei_pkg::SEL_NONE) ? cei_pkg::RESP_SLVERR : cei_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Last error code; a detected error in the same cycle beats a software clear
    logic       lec_clear;
    logic [2:0] next_last_err;

    assign lec_clear = wr_fire && wr_sel == cei_pkg::SEL_LAST_ERR && w_strb_q[0]
                       && w_data_q[7:0] == 8'h00;

    always_comb begin
        next_last_err = last_err;
        if (lec_clear)        next_last_err = cei_pkg::CODE_NONE;
        if (stuff_err)        next_last_err = cei_pkg::CODE_STUFF;
        else if (form_err)    next_last_err = cei_pkg::CODE_FORM;
        else if (ack_err)     next_last_err = cei_pkg::CODE_ACK;
        else if (bit_rec_err) next_last_err = cei_pkg::CODE_BIT_REC;
        else if (bit_dom_err) next_last_err = cei_pkg::CODE_BIT_DOM;
        else if (crc_err)     next_last_err = cei_pkg::CODE_CRC;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_err <= cei_pkg::LAST_ERR_RST;
        end else begin
            last_err <= next_last_err;
        end
    end

    // Counter clear request: software may only raise it in init mode
    logic clear_now;
    assign clear_now = clear_req && init_mode;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_req <= 1'b0;
        end else if (clear_now) begin
            clear_req <= 1'b0;
        end else if (wr_fire && wr_sel == cei_pkg::SEL_CONTROL && wr_val[cei_pkg::CLR_CNT_BIT] && init_mode) begin
            clear_req <= 1'b1;
        end
    end

    // Fault confinement counters
    logic [8:0] rx_sum;
    always_comb begin
        rx_sum = {1'b0, rx_count};
        if (rx_count_add8)      rx_sum = {1'b0, rx_count} + cei_pkg::STEP_BIG;
        else if (rx_count_add1) rx_sum = {1'b0, rx_count} + 9'h001;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_count <= cei_pkg::TX_COUNT_RST;
        end else if (clear_now || bus_off_recovered) begin
            tx_count <= cei_pkg::TX_COUNT_RST;
        end else if (!bus_off_flag) begin
            // Frozen once bus-off until recovery or a counter clear
            if (tx_count_add8) begin
                tx_count <= tx_count + cei_pkg::STEP_BIG;
            end else if (tx_count_sub1 && tx_count != 9'h000) begin
                tx_count <= tx_count - 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_count <= cei_pkg::RX_COUNT_RST;
        end else if (clear_now || bus_off_recovered) begin
            rx_count <= cei_pkg::RX_COUNT_RST;
        end else if (rx_count_add8 || rx_count_add1) begin
            rx_count <= rx_sum[8] ? cei_pkg::RX_MAX : rx_sum[7:0];
        end else if (rx_count_sub1) begin
            if ({1'b0, rx_count} >= cei_pkg::LVL_PASSIVE) begin
                rx_count <= cei_pkg::RX_EXIT_VALUE;
            end else if (rx_count != 8'h00) begin
                rx_count <= rx_count - 8'h01;
            end
        end
    end

    // Interrupt enable through set/clear pairs
    logic [5:0] en_set;
    logic [5:0] en_clr;
    assign en_set = (wr_fire && wr_sel == cei_pkg::SEL_ENABLE) ? wr_val[cei_pkg::SET_LSB +: 6] : 6'h00;
    assign en_clr = (wr_fire && wr_sel == cei_pkg::SEL_ENABLE) ? wr_val[5:0] : 6'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= cei_pkg::IRQ_ENABLE_RST;
        end else begin
            irq_enable <= (irq_enable | (en_set & ~en_clr)) & ~(en_clr & ~en_set);
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    logic [5:0] st_clr;
    assign st_clr = (wr_fire && wr_sel == cei_pkg::SEL_STATUS) ? wr_val[5:0] : 6'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status   <= cei_pkg::IRQ_STATUS_RST;
            summary_prev <= 8'h00;
        end else begin
            irq_status   <= (irq_status & ~st_clr) | irq_src;
            summary_prev <= error_state_summary;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // Checks
    property p_lec_ignore;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_fire && wr_sel == cei_pkg::SEL_LAST_ERR && w_data_q[7:0] != 8'h00 && !err_any) |=> $stable(last_err);
    endproperty
    a_lec_ignore: assert property (p_lec_ignore) else $error("nonzero write changed last error");

    property p_lec_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (!err_any && !lec_clear) |=> (last_err == $past(last_err));
    endproperty
    a_lec_hold: assert property (p_lec_hold) else $error("last error changed without cause");

    property p_bit_dom;
        @(posedge core_clk) disable iff (!rst_n)
        (bit_dom_err && !stuff_err && !form_err && !ack_err && !bit_rec_err) |=> (last_err == 3'h5);
    endproperty
    a_bit_dom: assert property (p_bit_dom) else $error("dominant bit error not coded 5");

    property p_bus_off;
        @(posedge core_clk) disable iff (!rst_n)
        (tx_count >= 9'h0F8 && tx_count < 9'h100 && tx_count_add8 && !clear_now && !bus_off_recovered)
            |=> error_state_summary[cei_pkg::BUS_OFF_BIT] ##1 error_state_summary[cei_pkg::BUS_OFF_BIT];
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus-off flag missing at count 256");

    property p_tx_level;
        @(posedge core_clk) disable iff (!rst_n)
        (tx_level != 2'h2) && ((tx_count < 9'h060) == (tx_level == 2'h0));
    endproperty
    a_tx_level: assert property (p_tx_level) else $error("transmit level field wrong");

    property p_rx_pass;
        @(posedge core_clk) disable iff (!rst_n)
        error_counters[15] == (rx_level == 2'h3);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("passive flag disagrees with level");

    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        clear_now |=> (error_counters == 16'h0000 && error_state_summary == 8'h00 && !clear_req);
    endproperty
    a_clear: assert property (p_clear) else $error("counter clear did not complete");

    property p_en_set;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_fire && wr_sel == cei_pkg::SEL_ENABLE && w_strb_q[1:0] == 2'h3 && w_data_q[13] && !w_data_q[5])
            |=> irq_enable[5];
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set bit ignored");

    property p_irq_gate;
        @(posedge core_clk) disable iff (!rst_n)
        (irq_enable == 6'h00) |=> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while all disabled");

endmodule // cei_top

`default_nettype wire

// [tb/cei_engine_model.sv]
// Behavioural protocol engine that issues error, counter step and interrupt event pulses
`timescale 1ns/1ps
`default_nettype none

module cei_engine_model (
    // Clock
    input  wire logic        core_clk,
    // Request from the bench
    input  wire logic        evt_go,
    input  wire logic [3:0]  evt_sel,
    // One-cycle pulses toward the block
    output logic      [15:0] pulse
);
    // One line per request, so every counter step arrives as its own pulse
    always_ff @(posedge core_clk) begin
        pulse <= evt_go ? (16'h0001 << evt_sel) : 16'h0000;
    end
endmodule // cei_engine_model

`default_nettype wire

// [tb/test_can_error_status_irq_enable.sv]
// Self-checking bench for the CAN error status and interrupt enable block
`timescale 1ns/1ps
`default_nettype none

module test_can_error_status_irq_enable;
    localparam logic [19:0] A_LE = {2'h0, cei_pkg::IDX_LAST_ERR, 2'h0};
    localparam logic [19:0] A_SU = {2'h0, cei_pkg::IDX_ERR_SUMMARY, 2'h0};
    localparam logic [19:0] A_CN = {2'h0, cei_pkg::IDX_ERR_COUNT, 2'h0};
    localparam logic [19:0] A_IE = {2'h0, cei_pkg::IDX_IRQ_ENABLE, 2'h0};
    localparam logic [19:0] A_ST = {2'h0, cei_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [19:0] A_CT = {2'h0, cei_pkg::IDX_CONTROL, 2'h0};
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [19:0] awaddr = 20'h0, araddr = 20'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        init_mode = 1'b0, evt_go = 1'b0;
    logic [3:0]  evt_sel = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, data;
    logic [15:0] pulse;
    int          num_errors = 0;
    int          comparisons = 0;
    // Error line to pulse beside the code it should leave behind
    logic [6:0]  rows [6] = '{{4'h0, cei_pkg::CODE_STUFF}, {4'h1, cei_pkg::CODE_FORM}, {4'h2, cei_pkg::CODE_ACK},
                              {4'h3, cei_pkg::CODE_BIT_REC}, {4'h4, cei_pkg::CODE_BIT_DOM}, {4'h5, cei_pkg::CODE_CRC}};

    always #5 core_clk = ~core_clk;

    cei_top #(.ADDR_W(20)) u_dut (
        .core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .init_mode(init_mode), .stuff_err(pulse[0]), .form_err(pulse[1]), .ack_err(pulse[2]),
        .bit_rec_err(pulse[3]), .bit_dom_err(pulse[4]), .crc_err(pulse[5]),
        .tx_count_add8(pulse[6]), .tx_count_sub1(pulse[7]), .rx_count_add1(pulse[8]),
        .rx_count_add8(pulse[9]), .rx_count_sub1(pulse[10]), .bus_off_recovered(pulse[11]),
        .wakeup_evt(pulse[12]), .arb_loss_evt(pulse[13]), .rx_valid_evt(pulse[14]),
        .tx_done_evt(pulse[15]), .irq(irq)
    );

    cei_engine_model u_engine (.core_clk(core_clk), .evt_go(evt_go), .evt_sel(evt_sel), .pulse(pulse));

    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Handshakes are judged at the falling edge, where nothing moves, then acted on after the rise
    task automatic wr(input logic [19:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        int   n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin bready <= 1'b0; break; end
        end
        // One idle edge so a following call never re-drives bready in the same step
        @(posedge core_clk);
        if (n == 50) begin num_errors++; give_verdict(); end
    endtask

    task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        int   n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ar = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 1'b0;
            if (v) begin rready <= 1'b0; break; end
        end
        @(posedge core_clk);
        if (n == 50) begin num_errors++; give_verdict(); end
    endtask

    task automatic rdc(input string nm, input logic [19:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFFFFFF);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, e & m, d & m);
    endtask

    // Pulses are spaced one idle cycle apart, as the engine never repeats a line back to back
    task automatic ev(input logic [3:0] s, input int k);
        repeat (k) begin
            evt_sel <= s;
            evt_go <= 1'b1;
            @(posedge core_clk);
            evt_go <= 1'b0;
            @(posedge core_clk);
        end
        repeat (2) @(posedge core_clk);
    endtask

    task automatic ck_irq(input logic e);
        @(negedge core_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge core_clk);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc("last_err", A_LE, 32'h0);
        rdc("summary", A_SU, 32'h0);
        rdc("counters", A_CN, 32'h0);
        rdc("irq_enable", A_IE, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ev(rows[i][6:3], 1);
            rdc("last_err", A_LE, {29'h0, rows[i][2:0]});
        end
        wr(A_LE, 32'h5, resp);
        rdc("last_err", A_LE, {29'h0, cei_pkg::CODE_CRC});
        wr(A_LE, 32'h0, resp);
        rdc("last_err", A_LE, 32'h0);
        ev(4'h2, 1);
        init_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdc("last_err", A_LE, {29'h0, cei_pkg::CODE_ACK});
        init_mode <= 1'b0;
        ev(4'h9, 12);
        rdc("counters", A_CN, 32'h6000);
        rdc("summary", A_SU, 32'h01);
        ev(4'h6, 12);
        rdc("counters", A_CN, 32'h6060);
        rdc("summary", A_SU, 32'h05);
        ev(4'h9, 4);
        ev(4'h6, 4);
        rdc("counters", A_CN, 32'h8080, 32'h80FF);
        rdc("summary", A_SU, 32'h0F);
        ev(4'h7, 1);
        rdc("counters", A_CN, 32'h807F, 32'h80FF);
        rdc("summary", A_SU, 32'h07);
        ev(4'h6, 17);
        rdc("summary", A_SU, 32'h1F);
        rdc("counters", A_CN, 32'h8000, 32'hFFFF8000);
        // Leaving receive passive drops to 119, then one more error
        ev(4'hA, 1);
        ev(4'h8, 1);
        rdc("counters", A_CN, 32'h7800, 32'hFF00);
        rdc("summary", A_SU, 32'h1D);
        ev(4'hB, 1);
        rdc("counters", A_CN, 32'h0);
        // Give the clear request something to clear
        ev(4'h9, 1);
        ev(4'h6, 1);
        init_mode <= 1'b1;
        wr(A_CT, 32'h1, resp);
        repeat (3) @(posedge core_clk);
        rdc("counters", A_CN, 32'h0);
        rdc("summary", A_SU, 32'h0);
        rdc("control", A_CT, 32'h0);
        init_mode <= 1'b0;
        wr(A_ST, 32'h3F, resp);
        wr(A_IE, 32'h3F00, resp);
        chk("bresp", {30'h0, cei_pkg::RESP_OKAY}, {30'h0, resp});
        rdc("irq_enable", A_IE, 32'h3F);
        wr(A_IE, 32'h0101, resp);
        rdc("irq_enable", A_IE, 32'h3F);
        wr(A_IE, 32'hC01F, resp);
        rdc("irq_enable", A_IE, 32'h20);
        ck_irq(1'b0);
        ev(4'hD, 1);
        ev(4'hE, 1);
        ev(4'hF, 1);
        ck_irq(1'b0);
        rdc("irq_status", A_ST, 32'h13);
        ev(4'hC, 1);
        ck_irq(1'b1);
        rdc("irq_status", A_ST, 32'h33);
        wr(A_ST, 32'h30, resp);
        repeat (2) @(posedge core_clk);
        ck_irq(1'b0);
        rdc("irq_status", A_ST, 32'h03);
        wr(20'h00100, 32'h1, resp);
        chk("bresp", {30'h0, cei_pkg::RESP_SLVERR}, {30'h0, resp});
        rd(20'h00100, data, resp);
        chk("rdata", 32'h0, data);
        chk("rresp", {30'h0, cei_pkg::RESP_SLVERR}, {30'h0, resp});
        // Reset in mid-run must drop the enables set above
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc("irq_enable", A_IE, 32'h0);
        ck_irq(1'b0);
        give_verdict();
    end
endmodule // test_can_error_status_irq_enable

`default_nettype wire
